// file: design/met_exec_tail.sv
// Execute unit for the subtract, swap, skip, table read and xor instruction group
`timescale 1ns/1ps
module met_exec_tail
	import met_pkg::*;
(
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic instrValid,
	input wire met_pkg::met_op_type instrOp,
	input wire logic [met_pkg::RAM_ADDR_W-1:0] instrAddr,
	input wire logic [met_pkg::DATA_W-1:0] instrImm,
	input wire logic [2:0] instrBit,
	output logic instrReady,
	output logic instrDone,
	output logic discardNext,
	input wire logic [3:0] pcPage,
	output logic progRead,
	output logic [met_pkg::PROG_ADDR_W-1:0] progAddr,
	input wire logic [met_pkg::PROG_W-1:0] progData,
	input wire logic [met_pkg::BUS_ADDR_W-1:0] busAddr,
	input wire logic [met_pkg::DATA_W-1:0] busWrData,
	input wire logic busWr,
	input wire logic busRd,
	output logic [met_pkg::DATA_W-1:0] busRdData
);
	import met_pkg::*;

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed
	{
		met_state_type state;
		met_op_type op;
		logic [RAM_ADDR_W-1:0] addr;
		logic [DATA_W-1:0] imm;
		logic [2:0] bitSel;
		logic [DATA_W-1:0] work;
		logic [DATA_W-1:0] tpl;
		logic [DATA_W-1:0] tph;
		logic [6:0] thl;
		logic [3:0] flags;
		logic hiEnable;
		logic progRead;
		logic [PROG_ADDR_W-1:0] progAddr;
		logic [DATA_W-1:0] rdData;
	} met_regs_type;

	met_regs_type core_reg;
	met_regs_type core_next;

	logic [DATA_W-1:0] memRd;
	logic memWrEn;
	logic [DATA_W-1:0] memWrData;
	logic [DATA_W-1:0] aluResult;
	logic [3:0] aluFlags;
	logic aluSkip;
	logic inExec;

	function automatic logic isTable(input met_op_type op);
		isTable = (op == OP_TABLE_PAGED) || (op == OP_TABLE_LAST);
	endfunction

	function automatic logic writesWork(input met_op_type op);
		writesWork = (op == OP_SUB_IMM) || (op == OP_SWAP_WORK) || (op == OP_LOAD_SKIP) ||
			(op == OP_XOR_WORK) || (op == OP_XOR_IMM);
	endfunction

	function automatic logic writesMem(input met_op_type op);
		writesMem = (op == OP_SWAP_MEM) || (op == OP_XOR_MEM) || isTable(op);
	endfunction

	function automatic logic [PROG_ADDR_W-1:0] tableAddr(input met_op_type op, input logic hi,
		input logic [7:0] tph, input logic [7:0] tpl, input logic [3:0] page);
		if (op == OP_TABLE_LAST)
			tableAddr = {LAST_PAGE, tpl};
		else if (hi)
			tableAddr = {tph[3:0], tpl};
		else
			tableAddr = {page, tpl};
	endfunction

	// ----------------------------------------
	// Datapath helpers
	// ----------------------------------------
	assign inExec = (core_reg.state == ST_EXEC);

	met_alu met_alu_inst
	(
		.op(core_reg.op),
		.work(core_reg.work),
		.memData(memRd),
		.imm(core_reg.imm),
		.bitSel(core_reg.bitSel),
		.flagsIn(core_reg.flags),
		.result(aluResult),
		.flagsOut(aluFlags),
		.skip(aluSkip)
	);

	// Low byte of the fetched word goes to memory, high part to the latch
	assign memWrEn = inExec && writesMem(core_reg.op);
	assign memWrData = isTable(core_reg.op) ? progData[7:0] : aluResult;

	met_data_ram met_data_ram_inst
	(
		.sys_clk(sys_clk),
		.nrst(nrst),
		.wrEn(memWrEn),
		.wrAddr(core_reg.addr),
		.wrData(memWrData),
		.rdEn(core_reg.state == ST_FETCH),
		.rdAddr(core_reg.addr),
		.rdData(memRd)
	);

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb
	begin
		core_next = core_reg;
		core_next.progRead = 1'b0;
		// Software writes first so that a finishing instruction wins the same cycle
		if (busWr)
		begin
			case (busAddr)
				OFS_WORK: core_next.work = busWrData;
				OFS_TPL: core_next.tpl = busWrData;
				OFS_TPH: core_next.tph = busWrData;
				OFS_FLAGS: core_next.flags = busWrData[3:0];
				OFS_CTRL: core_next.hiEnable = busWrData[CTRL_HIPTR];
				default: core_next.hiEnable = core_reg.hiEnable;
			endcase
		end
		if (busRd)
		begin
			case (busAddr)
				OFS_WORK: core_next.rdData = core_reg.work;
				OFS_TPL: core_next.rdData = core_reg.tpl;
				OFS_TPH: core_next.rdData = core_reg.tph;
				OFS_THL: core_next.rdData = {1'b0, core_reg.thl};
				OFS_FLAGS: core_next.rdData = {4'h0, core_reg.flags};
				OFS_CTRL: core_next.rdData = {7'h00, core_reg.hiEnable};
				default: core_next.rdData = RST_BYTE;
			endcase
		end
		case (core_reg.state)
			ST_IDLE:
			begin
				if (instrValid)
				begin
					core_next.op = instrOp;
					core_next.addr = instrAddr;
					core_next.imm = instrImm;
					core_next.bitSel = instrBit;
					core_next.state = ST_FETCH;
					core_next.progRead = isTable(instrOp);
					// Pointers are taken at accept; a later pointer write hits the next read
					core_next.progAddr = tableAddr(instrOp, core_reg.hiEnable, core_reg.tph,
						core_reg.tpl, pcPage);
				end
			end
			ST_FETCH:
				core_next.state = ST_EXEC;
			ST_EXEC:
			begin
				if (writesWork(core_reg.op))
					core_next.work = aluResult;
				core_next.flags = aluFlags;
				if (isTable(core_reg.op))
					core_next.thl = progData[14:8];
				core_next.state = aluSkip ? ST_DUMMY : ST_IDLE;
			end
			ST_DUMMY:
				core_next.state = ST_IDLE;
			default:
				core_next.state = ST_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			core_reg.state <= ST_IDLE;
			core_reg.op <= OP_SUB_IMM;
			core_reg.addr <= RST_BYTE;
			core_reg.imm <= RST_BYTE;
			core_reg.bitSel <= 3'h0;
			core_reg.work <= RST_BYTE;
			core_reg.tpl <= RST_BYTE;
			core_reg.tph <= RST_BYTE;
			core_reg.thl <= RST_THL;
			core_reg.flags <= RST_FLAGS;
			core_reg.hiEnable <= 1'b0;
			core_reg.progRead <= 1'b0;
			core_reg.progAddr <= RST_PADDR;
			core_reg.rdData <= RST_BYTE;
		end
		else
			core_reg <= core_next;
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign instrReady = (core_reg.state == ST_IDLE);
	assign instrDone = (inExec && !aluSkip) || (core_reg.state == ST_DUMMY);
	assign discardNext = (core_reg.state == ST_DUMMY);
	assign progRead = core_reg.progRead;
	assign progAddr = core_reg.progAddr;
	assign busRdData = core_reg.rdData;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	property p_sub_result;
		@(posedge sys_clk) disable iff (!nrst)
		inExec && core_reg.op == OP_SUB_IMM && !busWr |=> core_reg.work == $past(core_reg.work) - $past(core_reg.imm);
	endproperty
	a_sub_result: assert property (p_sub_result) else $error("subtract result wrong");

	property p_swap_mem;
		@(posedge sys_clk) disable iff (!nrst)
		inExec && core_reg.op == OP_SWAP_MEM |-> memWrEn && memWrData == {memRd[3:0], memRd[7:4]};
	endproperty
	a_swap_mem: assert property (p_swap_mem) else $error("memory swap wrong");

	property p_swap_work;
		@(posedge sys_clk) disable iff (!nrst)
		inExec && core_reg.op == OP_SWAP_WORK && !busWr |-> !memWrEn ##1
			core_reg.work == {$past(memRd[3:0]), $past(memRd[7:4])} && $stable(core_reg.flags);
	endproperty
	a_swap_work: assert property (p_swap_work) else $error("work swap wrong");

	property p_skip_null;
		@(posedge sys_clk) disable iff (!nrst)
		inExec && core_reg.op == OP_SKIP_NULL && memRd == 8'h00 |=> discardNext ##1 instrReady;
	endproperty
	a_skip_null: assert property (p_skip_null) else $error("null skip timing wrong");

	property p_load_skip;
		@(posedge sys_clk) disable iff (!nrst)
		inExec && core_reg.op == OP_LOAD_SKIP && !busWr |=> core_reg.work == $past(memRd) &&
			discardNext == ($past(memRd) == 8'h00);
	endproperty
	a_load_skip: assert property (p_load_skip) else $error("load skip wrong");

	property p_bit_skip;
		@(posedge sys_clk) disable iff (!nrst)
		inExec && core_reg.op == OP_BIT_SKIP |=> discardNext == !$past(memRd[core_reg.bitSel]);
	endproperty
	a_bit_skip: assert property (p_bit_skip) else $error("bit skip wrong");

	property p_table_addr;
		@(posedge sys_clk) disable iff (!nrst)
		instrReady && instrValid && instrOp == OP_TABLE_PAGED && core_reg.hiEnable |=>
			progRead && progAddr == {$past(core_reg.tph[3:0]), $past(core_reg.tpl)};
	endproperty
	a_table_addr: assert property (p_table_addr) else $error("paged table address wrong");

	property p_table_page;
		@(posedge sys_clk) disable iff (!nrst)
		instrReady && instrValid && instrOp == OP_TABLE_PAGED && !core_reg.hiEnable |=>
			progAddr == {$past(pcPage), $past(core_reg.tpl)};
	endproperty
	a_table_page: assert property (p_table_page) else $error("current page address wrong");

	property p_table_last;
		@(posedge sys_clk) disable iff (!nrst)
		instrReady && instrValid && instrOp == OP_TABLE_LAST |=> progAddr[11:8] == LAST_PAGE ##2
			core_reg.thl == $past(progData[14:8]);
	endproperty
	a_table_last: assert property (p_table_last) else $error("last page read wrong");

	property p_xor_zero;
		@(posedge sys_clk) disable iff (!nrst)
		inExec && core_reg.op == OP_XOR_WORK && !busWr |=> core_reg.work == ($past(core_reg.work) ^ $past(memRd)) &&
			core_reg.flags[FLAG_Z] == (core_reg.work == 8'h00) && core_reg.flags[1:0] == $past(core_reg.flags[1:0]);
	endproperty
	a_xor_zero: assert property (p_xor_zero) else $error("xor with memory wrong");

	property p_xor_mem;
		@(posedge sys_clk) disable iff (!nrst)
		inExec && core_reg.op == OP_XOR_MEM |-> memWrEn && memWrData == (core_reg.work ^ memRd);
	endproperty
	a_xor_mem: assert property (p_xor_mem) else $error("xor to memory wrong");

	property p_xor_imm;
		@(posedge sys_clk) disable iff (!nrst)
		inExec && core_reg.op == OP_XOR_IMM && !busWr |=> core_reg.work == ($past(core_reg.work) ^ $past(core_reg.imm));
	endproperty
	a_xor_imm: assert property (p_xor_imm) else $error("xor immediate wrong");

	// Carry means no borrow, so it follows the unsigned compare of the operands
	property p_sub_flags;
		@(posedge sys_clk) disable iff (!nrst)
		inExec && core_reg.op == OP_SUB_IMM |=> core_reg.flags[FLAG_Z] == (core_reg.work == 8'h00) &&
			core_reg.flags[FLAG_C] == ($past(core_reg.work) >= $past(core_reg.imm));
	endproperty
	a_sub_flags: assert property (p_sub_flags) else $error("subtract zero or carry flag wrong");

	property p_swap_flags;
		@(posedge sys_clk) disable iff (!nrst)
		inExec && (core_reg.op == OP_SWAP_MEM || core_reg.op == OP_SWAP_WORK) |=> $stable(core_reg.flags);
	endproperty
	a_swap_flags: assert property (p_swap_flags) else $error("swap changed a flag");

	property p_skip_none;
		@(posedge sys_clk) disable iff (!nrst)
		inExec && core_reg.op == OP_SKIP_NULL && memRd != 8'h00 |-> instrDone ##1 instrReady && !discardNext;
	endproperty
	a_skip_none: assert property (p_skip_none) else $error("null test took a dummy cycle");

	property p_skip_flags;
		@(posedge sys_clk) disable iff (!nrst)
		inExec && (core_reg.op == OP_SKIP_NULL || core_reg.op == OP_LOAD_SKIP || core_reg.op == OP_BIT_SKIP) |=>
			$stable(core_reg.flags);
	endproperty
	a_skip_flags: assert property (p_skip_flags) else $error("skip changed a flag");

	property p_table_data;
		@(posedge sys_clk) disable iff (!nrst)
		inExec && (core_reg.op == OP_TABLE_PAGED || core_reg.op == OP_TABLE_LAST) |-> memWrEn &&
			memWrData == progData[7:0] ##1 core_reg.thl == $past(progData[14:8]) && $stable(core_reg.flags);
	endproperty
	a_table_data: assert property (p_table_data) else $error("table word split wrong");

	// Xor result is zero exactly when both operands match
	property p_xor_mem_flags;
		@(posedge sys_clk) disable iff (!nrst)
		inExec && core_reg.op == OP_XOR_MEM |=> core_reg.flags[FLAG_Z] == ($past(core_reg.work) == $past(memRd)) &&
			core_reg.flags[FLAG_OV] == $past(core_reg.flags[FLAG_OV]) && core_reg.flags[1:0] == $past(core_reg.flags[1:0]);
	endproperty
	a_xor_mem_flags: assert property (p_xor_mem_flags) else $error("xor to memory flags wrong");
endmodule

// file: inc/met_pkg.sv
// Constants and types shared by the execute-tail block
package met_pkg;

	// ----------------------------------------
	// Widths and sizes
	// ----------------------------------------
	localparam int DATA_W = 8;
	localparam int PROG_W = 15;
	localparam int PROG_ADDR_W = 12;
	localparam int RAM_DEPTH = 160;
	localparam int RAM_ADDR_W = 8;
	localparam int BUS_ADDR_W = 4;

	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [3:0] OFS_WORK = 4'h0;
	localparam logic [3:0] OFS_TPL = 4'h1;
	localparam logic [3:0] OFS_TPH = 4'h2;
	localparam logic [3:0] OFS_THL = 4'h3;
	localparam logic [3:0] OFS_FLAGS = 4'h4;
	localparam logic [3:0] OFS_CTRL = 4'h5;

	// ----------------------------------------
	// Field positions and reset values
	// ----------------------------------------
	localparam int FLAG_C = 0;
	localparam int FLAG_AC = 1;
	localparam int FLAG_Z = 2;
	localparam int FLAG_OV = 3;
	localparam int CTRL_HIPTR = 0;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [6:0] RST_THL = 7'h00;
	localparam logic [3:0] RST_FLAGS = 4'h0;
	localparam logic [11:0] RST_PADDR = 12'h000;
	localparam logic [3:0] LAST_PAGE = 4'hF;

	// ----------------------------------------
	// Operations and states
	// ----------------------------------------
	typedef enum logic [3:0] {
		OP_SUB_IMM = 4'h0,
		OP_SWAP_MEM = 4'h1,
		OP_SWAP_WORK = 4'h2,
		OP_SKIP_NULL = 4'h3,
		OP_LOAD_SKIP = 4'h4,
		OP_BIT_SKIP = 4'h5,
		OP_TABLE_PAGED = 4'h6,
		OP_TABLE_LAST = 4'h7,
		OP_XOR_WORK = 4'h8,
		OP_XOR_MEM = 4'h9,
		OP_XOR_IMM = 4'hA
	} met_op_type;

	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_FETCH = 4'h2,
		ST_EXEC = 4'h4,
		ST_DUMMY = 4'h8
	} met_state_type;

endpackage

// file: design/met_data_ram.sv
// Data memory with registered read port
`timescale 1ns/1ps
module met_data_ram
	import met_pkg::*;
(
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic wrEn,
	input wire logic [met_pkg::RAM_ADDR_W-1:0] wrAddr,
	input wire logic [met_pkg::DATA_W-1:0] wrData,
	input wire logic rdEn,
	input wire logic [met_pkg::RAM_ADDR_W-1:0] rdAddr,
	output logic [met_pkg::DATA_W-1:0] rdData
);
	import met_pkg::*;

	typedef struct packed
	{
		logic [RAM_DEPTH-1:0][DATA_W-1:0] cells;
		logic [DATA_W-1:0] rd;
	} met_ram_type;

	met_ram_type ram_reg;
	met_ram_type ram_next;

	// ----------------------------------------
	// Access
	// ----------------------------------------
	// Addresses past the top are dropped on write and read as zero
	always_comb
	begin
		ram_next = ram_reg;
		if (rdEn)
		begin
			ram_next.rd = (rdAddr < RAM_DEPTH) ? ram_reg.cells[rdAddr] : RST_BYTE;
		end
		if (wrEn && (wrAddr < RAM_DEPTH))
		begin
			ram_next.cells[wrAddr] = wrData;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
			ram_reg <= '0;
		else
			ram_reg <= ram_next;
	end

	assign rdData = ram_reg.rd;
endmodule

// file: design/met_alu.sv
// Result, flag and skip logic for the execute-tail operations
`timescale 1ns/1ps
module met_alu
	import met_pkg::*;
(
	input wire met_pkg::met_op_type op,
	input wire logic [met_pkg::DATA_W-1:0] work,
	input wire logic [met_pkg::DATA_W-1:0] memData,
	input wire logic [met_pkg::DATA_W-1:0] imm,
	input wire logic [2:0] bitSel,
	input wire logic [3:0] flagsIn,
	output logic [met_pkg::DATA_W-1:0] result,
	output logic [3:0] flagsOut,
	output logic skip
);
	import met_pkg::*;

	logic [8:0] diff;
	logic [4:0] lowDiff;
	logic [7:0] notImm;

	assign notImm = ~imm;
	assign diff = {1'b0, work} + {1'b0, notImm} + 9'h001;
	assign lowDiff = {1'b0, work[3:0]} + {1'b0, notImm[3:0]} + 5'h01;

	// ----------------------------------------
	// Per operation
	// ----------------------------------------
	always_comb
	begin
		result = RST_BYTE;
		flagsOut = flagsIn;
		skip = 1'b0;
		case (op)
			OP_SUB_IMM:
			begin
				result = diff[7:0];
				flagsOut[FLAG_C] = diff[8];
				flagsOut[FLAG_AC] = lowDiff[4];
				flagsOut[FLAG_OV] = (work[7] == notImm[7]) && (diff[7] != work[7]);
				flagsOut[FLAG_Z] = (diff[7:0] == RST_BYTE);
			end
			OP_SWAP_MEM, OP_SWAP_WORK:
				result = {memData[3:0], memData[7:4]};
			OP_SKIP_NULL:
				skip = (memData == RST_BYTE);
			OP_LOAD_SKIP:
			begin
				result = memData;
				skip = (memData == RST_BYTE);
			end
			OP_BIT_SKIP:
				skip = !memData[bitSel];
			OP_XOR_WORK, OP_XOR_MEM:
			begin
				result = work ^ memData;
				flagsOut[FLAG_Z] = ((work ^ memData) == RST_BYTE);
			end
			OP_XOR_IMM:
			begin
				result = work ^ imm;
				flagsOut[FLAG_Z] = ((work ^ imm) == RST_BYTE);
			end
			default:
				result = RST_BYTE;
		endcase
	end
endmodule

// file: test/test_met_exec_tail.sv
// Self-checking bench for the execute-tail block
`timescale 1ns/1ps
module test_met_exec_tail;
	import met_pkg::*;
	logic sys_clk = 1'b0;
	logic nrst = 1'b0;
	logic instrValid = 1'b0;
	met_op_type instrOp = OP_SUB_IMM;
	logic [7:0] instrAddr = 8'h00;
	logic [7:0] instrImm = 8'h00;
	logic [2:0] instrBit = 3'h0;
	logic instrReady;
	logic instrDone;
	logic discardNext;
	logic [3:0] pcPage = 4'h2;
	logic progRead;
	logic [11:0] progAddr;
	logic [14:0] progData = 15'h0000;
	logic [3:0] busAddr = 4'h0;
	logic [7:0] busWrData = 8'h00;
	logic busWr = 1'b0;
	logic busRd = 1'b0;
	logic [7:0] busRdData;
	int nFail = 0;
	int samplesChecked = 0;
	logic [7:0] rd;
	logic [11:0] seenAddr;
	logic seenRd;

	always #20 sys_clk = ~sys_clk;

	met_exec_tail met_exec_tail_inst (.sys_clk(sys_clk), .nrst(nrst), .instrValid(instrValid), .instrOp(instrOp),
		.instrAddr(instrAddr), .instrImm(instrImm), .instrBit(instrBit), .instrReady(instrReady),
		.instrDone(instrDone), .discardNext(discardNext), .pcPage(pcPage), .progRead(progRead),
		.progAddr(progAddr), .progData(progData), .busAddr(busAddr), .busWrData(busWrData), .busWr(busWr),
		.busRd(busRd), .busRdData(busRdData));

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		samplesChecked++;
		if (seen !== exp)
		begin
			nFail++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask

	task printVerdict;
		$display("checked %0d, mismatches %0d", samplesChecked, nFail);
		if (nFail == 0 && samplesChecked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// Each task waits an edge first, so a strobe is never raised in the step that lowered it
	task busW(input logic [3:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		busAddr <= a;
		busWrData <= d;
		busWr <= 1'b1;
		@(posedge sys_clk);
		busWr <= 1'b0;
	endtask

	task busR(input logic [3:0] a, output logic [7:0] d);
		@(posedge sys_clk);
		busAddr <= a;
		busRd <= 1'b1;
		@(posedge sys_clk);
		busRd <= 1'b0;
		#1;
		d = busRdData;
	endtask

	task exec(input met_op_type op, input logic [7:0] a, input logic [7:0] x, input logic [2:0] b, input logic sk);
		int n;
		@(posedge sys_clk);
		instrValid <= 1'b1;
		instrOp <= op;
		instrAddr <= a;
		instrImm <= x;
		instrBit <= b;
		@(posedge sys_clk);
		instrValid <= 1'b0;
		#1;
		seenRd = progRead;
		seenAddr = progAddr;
		n = 1;
		while (instrDone !== 1'b1 && n < 8)
		begin
			@(posedge sys_clk);
			#1;
			n++;
		end
		check("cycles", 16'(n), sk ? 16'h0003 : 16'h0002);
		check("discard", {15'h0000, discardNext}, {15'h0000, sk});
	endtask

	// Memory is only visible through instructions, so a load-and-skip pulls it into work
	task peek(input logic [7:0] a, input logic [7:0] exp);
		exec(OP_LOAD_SKIP, a, 8'h00, 3'h0, exp == 8'h00);
		busR(OFS_WORK, rd);
		check("memory byte", {8'h00, rd}, {8'h00, exp});
	endtask

	task flagsAre(input logic [3:0] exp);
		busR(OFS_FLAGS, rd);
		check("flags", {12'h000, rd[3:0]}, {12'h000, exp});
	endtask

	// ----------------------------------------
	// Watchdog
	// ----------------------------------------
	initial
	begin
		#400000;
		nFail++;
		printVerdict;
	end

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial
	begin
		logic [7:0] subW [4];
		logic [7:0] subX [4];
		logic [8:0] s9;
		logic [4:0] h5;
		logic [3:0] offs [7];
		met_op_type tOp [3];
		logic [14:0] tWord [3];
		logic [11:0] tAddr [3];
		logic [7:0] tMem [3];
		subW = '{8'h05, 8'h03, 8'h80, 8'h10};
		subX = '{8'h05, 8'h05, 8'h01, 8'h01};
		offs = '{OFS_WORK, OFS_TPL, OFS_TPH, OFS_THL, OFS_FLAGS, OFS_CTRL, 4'hF};
		tOp = '{OP_TABLE_PAGED, OP_TABLE_PAGED, OP_TABLE_LAST};
		tWord = '{15'h5ABC, 15'h7F81, 15'h2D00};
		tAddr = '{12'h733, 12'h233, 12'hF33};
		tMem = '{8'h30, 8'h31, 8'h20};
		repeat (6) @(posedge sys_clk);
		check("ready in reset", {15'h0000, instrReady}, 16'h0001);
		nrst <= 1'b1;
		foreach (offs[i])
		begin
			busR(offs[i], rd);
			check("reset value", {8'h00, rd}, 16'h0000);
		end
		busW(OFS_TPL, 8'h33);
		busW(OFS_TPH, 8'h07);
		busW(OFS_THL, 8'hFF);
		busR(OFS_TPL, rd);
		check("low pointer", {8'h00, rd}, 16'h0033);
		busR(OFS_THL, rd);
		check("latch is read-only", {8'h00, rd}, 16'h0000);
		for (int i = 0; i < 4; i++)
		begin
			busW(OFS_WORK, subW[i]);
			exec(OP_SUB_IMM, 8'h00, subX[i], 3'h0, 1'b0);
			s9 = {1'b0, subW[i]} + {1'b0, ~subX[i]} + 9'h001;
			h5 = {1'b0, subW[i][3:0]} + {1'b0, ~subX[i][3:0]} + 5'h01;
			busR(OFS_WORK, rd);
			check("difference", {8'h00, rd}, {8'h00, s9[7:0]});
			flagsAre({(subW[i][7] ^ subX[i][7]) & (s9[7] ^ subW[i][7]), s9[7:0] == 8'h00, h5[4], s9[8]});
		end
		// Preset C, AC and wrap so any stray flag write shows
		busW(OFS_FLAGS, 8'h0B);
		busW(OFS_WORK, 8'hA5);
		exec(OP_LOAD_SKIP, 8'h10, 8'h00, 3'h0, 1'b1);
		busW(OFS_WORK, 8'hA5);
		exec(OP_XOR_MEM, 8'h10, 8'h00, 3'h0, 1'b0);
		exec(OP_XOR_MEM, 8'h10, 8'h00, 3'h0, 1'b0);
		flagsAre(4'hF);
		busW(OFS_WORK, 8'hA5);
		exec(OP_XOR_MEM, 8'h10, 8'h00, 3'h0, 1'b0);
		flagsAre(4'hB);
		peek(8'h10, 8'hA5);
		exec(OP_XOR_WORK, 8'h10, 8'h00, 3'h0, 1'b0);
		busR(OFS_WORK, rd);
		check("xor with memory", {8'h00, rd}, 16'h0000);
		flagsAre(4'hF);
		exec(OP_XOR_IMM, 8'h00, 8'h3C, 3'h0, 1'b0);
		busR(OFS_WORK, rd);
		check("xor with immediate", {8'h00, rd}, 16'h003C);
		flagsAre(4'hB);
		exec(OP_SWAP_MEM, 8'h10, 8'h00, 3'h0, 1'b0);
		peek(8'h10, 8'h5A);
		exec(OP_SWAP_WORK, 8'h10, 8'h00, 3'h0, 1'b0);
		busR(OFS_WORK, rd);
		check("swap to work", {8'h00, rd}, 16'h00A5);
		peek(8'h10, 8'h5A);
		flagsAre(4'hB);
		for (int i = 0; i < 3; i++)
		begin
			busW(OFS_CTRL, (i == 0) ? 8'h01 : 8'h00);
			progData <= tWord[i];
			exec(tOp[i], tMem[i], 8'h00, 3'h0, 1'b0);
			check("program read", {15'h0000, seenRd}, 16'h0001);
			check("program address", {4'h0, seenAddr}, {4'h0, tAddr[i]});
			busR(OFS_THL, rd);
			check("table high latch", {8'h00, rd}, {8'h00, 1'b0, tWord[i][14:8]});
			peek(tMem[i], tWord[i][7:0]);
		end
		exec(OP_SKIP_NULL, 8'h20, 8'h00, 3'h0, 1'b1);
		exec(OP_SKIP_NULL, 8'h10, 8'h00, 3'h0, 1'b0);
		busW(OFS_WORK, 8'h77);
		exec(OP_LOAD_SKIP, 8'h20, 8'h00, 3'h0, 1'b1);
		busR(OFS_WORK, rd);
		check("load and skip", {8'h00, rd}, 16'h0000);
		for (int b = 0; b < 8; b++)
			exec(OP_BIT_SKIP, 8'h10, 8'h00, 3'(b), (8'h5A & (8'h01 << b)) == 8'h00);
		flagsAre(4'hB);
		printVerdict;
	end
endmodule
